// File: hw/fhb_flash_if.sv
// fhb_flash_if: pin-side bus interface of a x16 burst flash, with APB config.
// assumes: pins arrive asynchronously; core array answers rd_data one cycle
// after rd_addr; program/erase controller reports busy on mclk_i.
`timescale 1ns/10ps

// Functional notes
// - data captured at first ce/we rise
// - burst clock ignored during writes
// - address latched at earliest latch/ce/we rise
// - oe high floats data pins
// - ce high is standby, pins float
// - standby never stops program or erase
// - auto low power only in idle async reads
// - low power keeps driving read data
// - power-down floats every output
// - burst address at first edge or latch rise
// - first word after configured latency
// - burst drives data pins only with oe low
// - continuous burst walks whole array
// - unaligned continuous burst pulls ready low
// - ready timing selectable by config bit
// - burst only when read select zero
// - burst steps on selected clock edge
// - read select one means async, reset one
// - edge bit zero falling, one rising
// - ready low at, or before, invalid edge
// - latency codes 010..110 give 4..8
module fhb_flash_if import fhb_pkg::*; #(
  parameter int AW = 21,
  parameter int DW = 16
) (
  input  wire logic          mclk_i,
  input  wire logic          arst_n_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  input  wire logic          chip_en_n_i,
  input  wire logic          out_en_n_i,
  input  wire logic          wr_en_n_i,
  input  wire logic          latch_en_n_i,
  input  wire logic          reset_power_down_n_i,
  input  wire logic          burst_clk_i,
  input  wire logic [AW-1:0] word_address_pins_i,
  input  wire logic [DW-1:0] data_pins_i,
  output logic      [DW-1:0] data_pins_o,
  output logic               data_pins_oe_n_o,
  output logic               valid_ready_o,
  output logic               valid_ready_oe_n_o,
  output logic      [AW-1:0] core_rd_addr_o,
  input  wire logic [DW-1:0] core_rd_data_i,
  output logic               cmd_valid_o,
  output logic      [AW-1:0] cmd_addr_o,
  output logic      [DW-1:0] cmd_data_o,
  input  wire logic          pe_busy_i,
  output logic               standby_o,
  output logic               low_power_o,
  output logic               power_down_o
);

  // ==========================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================================
  // pin synchronisers and edges
  logic          ce_s, oe_s, we_s, le_s, rp_s, k_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] din_s;
  logic          k_rise, k_fall, le_rise;

  fhb_sync #(.W(6), .INIT(6'h1f)) u_sync_ctl (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .d_i     ({burst_clk_i, chip_en_n_i, out_en_n_i, wr_en_n_i, latch_en_n_i, reset_power_down_n_i}),
    .q_o     ({k_s, ce_s, oe_s, we_s, le_s, rp_s})
  );

  fhb_sync #(.W(AW), .INIT('0)) u_sync_addr (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .d_i     (word_address_pins_i),
    .q_o     (addr_s)
  );

  fhb_sync #(.W(DW), .INIT('0)) u_sync_data (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .d_i     (data_pins_i),
    .q_o     (din_s)
  );

  fhb_edge #(.INIT(1'b0)) u_edge_k (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .level_i (k_s),
    .rise_o  (k_rise),
    .fall_o  (k_fall)
  );

  fhb_edge #(.INIT(1'b1)) u_edge_le (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .level_i (le_s),
    .rise_o  (le_rise),
    .fall_o  ()
  );

  // ==========================================================
  // helpers
  function automatic logic in_burst(input fhb_bstate_t st);
    in_burst = (st == fhb_b_data) || (st == fhb_b_wait);
  endfunction

  // reserved codes clamp into the legal range
  function automatic logic [3:0] lat_cycles(input logic [2:0] code);
    logic [2:0] c;
    c = code;
    if (c < FHB_LAT_MIN) c = FHB_LAT_MIN;
    if (c > FHB_LAT_MAX) c = FHB_LAT_MAX;
    lat_cycles = {1'b0, c} + FHB_LAT_OFFSET;
  endfunction

  // ==========================================================
  // state
  logic [15:0]   cfg_reg, cfg_next;
  logic [31:0]   prdata_reg, prdata_next;
  logic [AW-1:0] latch_reg, latch_next;
  logic          wr_act_reg, wr_act_next;
  logic          cmd_valid_reg, cmd_valid_next;
  logic [AW-1:0] cmd_addr_reg, cmd_addr_next;
  logic [DW-1:0] cmd_data_reg, cmd_data_next;
  logic          pend_reg, pend_next;
  fhb_bstate_t   bst_reg, bst_next;
  logic [3:0]    lat_reg, lat_next;
  logic [AW-1:0] baddr_reg, baddr_next;
  logic          unal_reg, unal_next;
  logic          cross_reg, cross_next;
  logic [AW-1:0] rd_addr_reg, rd_addr_next;
  logic [DW-1:0] dout_reg, dout_next;
  logic [AW+3:0] snap_reg, snap_next;
  logic [7:0]    idle_reg, idle_next;
  logic          lp_reg, lp_next;

  logic          rsel, rtim, cedge, cont;
  logic          act_edge, apb_setup, apb_wr, capture;
  logic          start_ok, wait_cond, ready_pull, drive;
  logic [AW-1:0] eff_addr;
  logic [31:0]   status_w;
  logic          addr_hit;

  always_comb begin
    rsel      = cfg_reg[FHB_RSEL_BIT];
    rtim      = cfg_reg[FHB_RTIM_BIT];
    cedge     = cfg_reg[FHB_CEDGE_BIT];
    cont      = cfg_reg[FHB_BLEN_HI:FHB_BLEN_LO] == FHB_BLEN_CONT;
    act_edge  = cedge ? k_rise : k_fall;
    // transparent while latch low, frozen once it rises
    eff_addr  = le_s ? latch_reg : addr_s;
    apb_setup = psel_i && !penable_i;
    apb_wr    = psel_i && penable_i && pwrite_i;
    addr_hit  = (paddr_i == FHB_CFG_OFF) || (paddr_i == FHB_CMD_ADDR_OFF) ||
                (paddr_i == FHB_CMD_DATA_OFF) || (paddr_i == FHB_STATUS_OFF);
    capture   = wr_act_reg && (ce_s || we_s);
    start_ok  = !rsel && !ce_s && we_s && rp_s;
    wait_cond = cont && unal_reg && !cross_reg && (baddr_reg[1:0] == FHB_PAGE_LAST);
    status_w  = '0;
    status_w[FHB_ST_STANDBY] = ce_s;
    status_w[FHB_ST_LOWPWR]  = lp_reg;
    status_w[FHB_ST_PWRDN]   = !rp_s;
    status_w[FHB_ST_BURST]   = bst_reg != fhb_b_idle;
    status_w[FHB_ST_PEBUSY]  = pe_busy_i;
    status_w[FHB_ST_CMDPEND] = pend_reg;

    cfg_next       = cfg_reg;
    prdata_next    = prdata_reg;
    latch_next     = le_s ? latch_reg : addr_s;
    wr_act_next    = wr_act_reg;
    cmd_valid_next = 1'b0;
    cmd_addr_next  = cmd_addr_reg;
    cmd_data_next  = cmd_data_reg;
    pend_next      = pend_reg;
    bst_next       = bst_reg;
    lat_next       = lat_reg;
    baddr_next     = baddr_reg;
    unal_next      = unal_reg;
    cross_next     = cross_reg;
    dout_next      = core_rd_data_i;
    snap_next      = {ce_s, oe_s, we_s, le_s, addr_s};
    idle_next      = idle_reg;
    lp_next        = lp_reg;

    // register bus
    if (apb_setup && !pwrite_i) begin
      case (paddr_i)
        FHB_CFG_OFF:      prdata_next = {16'h0000, cfg_reg};
        FHB_CMD_ADDR_OFF: prdata_next = {{(32-AW){1'b0}}, cmd_addr_reg};
        FHB_CMD_DATA_OFF: prdata_next = {{(32-DW){1'b0}}, cmd_data_reg};
        FHB_STATUS_OFF:   prdata_next = status_w;
        default:          prdata_next = '0;
      endcase
    end
    if (apb_wr && paddr_i == FHB_CFG_OFF) begin
      cfg_next = (cfg_reg & ~FHB_CFG_WMASK) | (pwdata_i[15:0] & FHB_CFG_WMASK);
    end
    if (apb_wr && paddr_i == FHB_STATUS_OFF && pwdata_i[FHB_ST_CMDPEND]) begin
      pend_next = 1'b0;
    end
    if (!rp_s) begin
      cfg_next = FHB_CFG_RESET;
    end

    // asynchronous command write, burst clock not looked at
    if (capture) begin
      cmd_valid_next = 1'b1;
      cmd_addr_next  = eff_addr;
      cmd_data_next  = din_s;
      pend_next      = 1'b1;
      wr_act_next    = 1'b0;
    end else if (!ce_s && !we_s && oe_s) begin
      wr_act_next = 1'b1;
    end
    if (!rp_s) begin
      wr_act_next = 1'b0;
    end

    // synchronous burst
    case (bst_reg)
      fhb_b_idle: begin
        if (start_ok && ((act_edge && !le_s) || le_rise)) begin
          bst_next   = fhb_b_lat;
          baddr_next = eff_addr;
          lat_next   = lat_cycles(cfg_reg[FHB_LAT_HI:FHB_LAT_LO]);
          unal_next  = eff_addr[1:0] != FHB_PAGE_FIRST;
          cross_next = 1'b0;
        end
      end
      fhb_b_lat: begin
        if (act_edge) begin
          if (lat_reg <= 4'h1) begin
            bst_next = fhb_b_data;
          end else begin
            lat_next = lat_reg - 4'h1;
          end
        end
      end
      fhb_b_data: begin
        if (act_edge) begin
          if (wait_cond) begin
            bst_next = fhb_b_wait;
          end else begin
            baddr_next = baddr_reg + {{(AW-1){1'b0}}, 1'b1};
          end
        end
      end
      fhb_b_wait: begin
        if (act_edge) begin
          bst_next   = fhb_b_data;
          cross_next = 1'b1;
          baddr_next = baddr_reg + {{(AW-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        bst_next = fhb_b_idle;
      end
    endcase
    if (ce_s || !rp_s || rsel) begin
      bst_next = fhb_b_idle;
    end

    rd_addr_next = in_burst(bst_next) ? baddr_next : eff_addr;

    // idle watch for automatic low power; only affects the status
    if (!rsel || ce_s || !rp_s || snap_next != snap_reg) begin
      idle_next = '0;
      lp_next   = 1'b0;
    end else if (idle_reg >= 8'(FHB_IDLE_CYC - 1)) begin
      lp_next = 1'b1;
    end else begin
      idle_next = idle_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg       <= FHB_CFG_RESET;
      prdata_reg    <= '0;
      latch_reg     <= '0;
      wr_act_reg    <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_addr_reg  <= '0;
      cmd_data_reg  <= '0;
      pend_reg      <= 1'b0;
      bst_reg       <= fhb_b_idle;
      lat_reg       <= '0;
      baddr_reg     <= '0;
      unal_reg      <= 1'b0;
      cross_reg     <= 1'b0;
      rd_addr_reg   <= '0;
      dout_reg      <= '0;
      snap_reg      <= '0;
      idle_reg      <= '0;
      lp_reg        <= 1'b0;
    end else begin
      cfg_reg       <= cfg_next;
      prdata_reg    <= prdata_next;
      latch_reg     <= latch_next;
      wr_act_reg    <= wr_act_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_addr_reg  <= cmd_addr_next;
      cmd_data_reg  <= cmd_data_next;
      pend_reg      <= pend_next;
      bst_reg       <= bst_next;
      lat_reg       <= lat_next;
      baddr_reg     <= baddr_next;
      unal_reg      <= unal_next;
      cross_reg     <= cross_next;
      rd_addr_reg   <= rd_addr_next;
      dout_reg      <= dout_next;
      snap_reg      <= snap_next;
      idle_reg      <= idle_next;
      lp_reg        <= lp_next;
    end
  end

  // ==========================================================
  // pin drivers
  always_comb begin
    // low power does not gate the read path
    drive      = rp_s && !ce_s && !oe_s && we_s && (rsel || in_burst(bst_reg));
    ready_pull = rp_s && !ce_s && cont && in_burst(bst_reg) &&
                 (rtim ? (bst_reg == fhb_b_data && wait_cond) : (bst_reg == fhb_b_wait));
  end

  assign data_pins_o        = dout_reg;
  assign data_pins_oe_n_o   = !drive;
  assign valid_ready_o      = 1'b0;
  assign valid_ready_oe_n_o = !ready_pull;
  assign core_rd_addr_o     = rd_addr_reg;
  assign cmd_valid_o        = cmd_valid_reg;
  assign cmd_addr_o         = cmd_addr_reg;
  assign cmd_data_o         = cmd_data_reg;
  assign standby_o          = ce_s;
  assign low_power_o        = lp_reg;
  assign power_down_o       = !rp_s;
  assign prdata_o           = prdata_reg;
  assign pready_o           = 1'b1;
  assign pslverr_o          = psel_i && penable_i && !addr_hit;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  chk_oe_float: assert property (oe_s |-> data_pins_oe_n_o)
    else $error("data pins driven with oe high");
  chk_standby_float: assert property (ce_s |-> data_pins_oe_n_o && valid_ready_oe_n_o)
    else $error("data pins driven in standby");
  chk_pd_float: assert property (!rp_s |-> data_pins_oe_n_o && valid_ready_oe_n_o)
    else $error("output driven in power-down");
  chk_write_capture: assert property (wr_act_reg && (ce_s || we_s) |=> cmd_valid_o && cmd_data_o == $past(din_s))
    else $error("write word not captured");
  chk_write_noburst: assert property (!we_s && bst_reg == fhb_b_idle |=> bst_reg == fhb_b_idle)
    else $error("burst started during write");
  chk_lat_done: assert property (bst_reg == fhb_b_lat && act_edge && lat_reg == 4'h1 && !ce_s && rp_s && !rsel
                                 |=> bst_reg == fhb_b_data)
    else $error("latency end missed");
  chk_lat_load: assert property (bst_reg == fhb_b_idle ##1 bst_reg == fhb_b_lat
                                 |-> lat_reg == lat_cycles($past(cfg_reg[FHB_LAT_HI:FHB_LAT_LO])))
    else $error("latency count wrong");
  chk_ready_wait: assert property (bst_reg == fhb_b_wait && !rtim && cont && !ce_s && rp_s |-> !valid_ready_oe_n_o)
    else $error("ready not low on wait edge");
  chk_abort: assert property (ce_s && bst_reg != fhb_b_idle |=> bst_reg == fhb_b_idle)
    else $error("burst not aborted");
  chk_async_sel: assert property (rsel |=> bst_reg == fhb_b_idle)
    else $error("burst in async mode");
  chk_lp_mode: assert property (low_power_o |-> $past(rsel) && !$past(ce_s) && $past(rp_s))
    else $error("low power outside async read");
  chk_latch_hold: assert property (le_s && $past(le_s) |-> $stable(latch_reg))
    else $error("latched address moved");

endmodule

// File: include/fhb_pkg.sv
// fhb_pkg: constants, register map and types of the flash host bus port.
// assumes: APB slave with an 8-bit byte address, 32-bit data.
package fhb_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0]  FHB_CFG_OFF      = 8'h00;
  localparam logic [7:0]  FHB_CMD_ADDR_OFF = 8'h04;
  localparam logic [7:0]  FHB_CMD_DATA_OFF = 8'h08;
  localparam logic [7:0]  FHB_STATUS_OFF   = 8'h0c;

  // ==========================================================
  // burst configuration fields
  localparam int          FHB_RSEL_BIT   = 15;
  localparam int          FHB_LAT_HI     = 13;
  localparam int          FHB_LAT_LO     = 11;
  localparam int          FHB_RTIM_BIT   = 8;
  localparam int          FHB_CEDGE_BIT  = 6;
  localparam int          FHB_BLEN_HI    = 2;
  localparam int          FHB_BLEN_LO    = 0;
  localparam logic [15:0] FHB_CFG_RESET  = 16'h8000;
  localparam logic [15:0] FHB_CFG_WMASK  = 16'hb947;
  localparam logic [2:0]  FHB_BLEN_CONT  = 3'h7;
  localparam logic [2:0]  FHB_LAT_MIN    = 3'h2;
  localparam logic [2:0]  FHB_LAT_MAX    = 3'h6;
  localparam logic [3:0]  FHB_LAT_OFFSET = 4'h2;
  localparam logic [1:0]  FHB_PAGE_LAST  = 2'h3;
  localparam logic [1:0]  FHB_PAGE_FIRST = 2'h0;

  // ==========================================================
  // status bits
  localparam int          FHB_ST_STANDBY = 0;
  localparam int          FHB_ST_LOWPWR  = 1;
  localparam int          FHB_ST_PWRDN   = 2;
  localparam int          FHB_ST_BURST   = 3;
  localparam int          FHB_ST_PEBUSY  = 4;
  localparam int          FHB_ST_CMDPEND = 5;

  // ==========================================================
  // timing
  localparam int          FHB_CLK_NS     = 10;
  localparam int          FHB_IDLE_NS    = 200;
  localparam int          FHB_IDLE_CYC   = (FHB_IDLE_NS + FHB_CLK_NS - 1) / FHB_CLK_NS;

  typedef enum logic [1:0] {
    fhb_b_idle = 2'b00,
    fhb_b_lat  = 2'b01,
    fhb_b_data = 2'b11,
    fhb_b_wait = 2'b10
  } fhb_bstate_t;

endpackage

// File: hw/fhb_sync.sv
// fhb_sync: two-flop synchroniser for a bundle of pin levels.
// assumes: bits are independent levels; a skewed bundle settles within a cycle.
`timescale 1ns/10ps
module fhb_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d_i;
    q_next    = meta_reg;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= INIT;
      q_reg    <= INIT;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule

// File: hw/fhb_edge.sv
// fhb_edge: rise and fall pulses of an already synchronised level.
// assumes: input is on mclk_i; pulses last one cycle.
`timescale 1ns/10ps
module fhb_edge #(
  parameter logic INIT = 1'b0
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = level_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= INIT;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise_o = level_i & ~prev_reg;
  assign fall_o = ~level_i & prev_reg;

endmodule

// File: test/fhb_host_model.sv
// fhb_host_model: behavioural host memory controller on the flash pins.
// assumes: driven from the bench on mclk_i; burst clock only runs inside a burst.
`timescale 1ns/10ps
module fhb_host_model (
  input  wire logic        mclk_i,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic             le_n_o,
  output logic             rp_n_o,
  output logic             k_o,
  output logic [20:0]      a_o,
  output logic [15:0]      dq_o,
  output int               rises,
  output int               falls
);
  initial begin
    {ce_n_o, oe_n_o, we_n_o, le_n_o, rp_n_o, k_o} = 6'h3e;
    a_o = '0;
    dq_o = '0;
    rises = 0;
    falls = 0;
  end

  // ==========================================================
  // bus cycles
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // strobes held 4 cycles so the synchronisers see every level
  task automatic wr(input logic lat, input logic [20:0] a, input logic [15:0] d);
    a_o <= a;
    le_n_o <= 1'b0;
    ce_n_o <= 1'b0;
    dq_o <= d;
    step(4);
    if (lat) begin
      le_n_o <= 1'b1;
      step(4);
      a_o <= ~a;
    end
    we_n_o <= 1'b0;
    step(4);
    we_n_o <= 1'b1;
    step(4);
    ce_n_o <= 1'b1;
    le_n_o <= 1'b1;
    dq_o <= ~d;
    step(4);
  endtask

  // released data and address lines show the inverse, never the old value
  task automatic burst(input logic [20:0] a, input logic oe, input int n);
    a_o <= a;
    ce_n_o <= 1'b0;
    le_n_o <= 1'b0;
    oe_n_o <= oe;
    rises = 0;
    falls = 0;
    for (int i = 0; i < 2 * n; i++) begin
      step(8);
      k_o <= ~k_o;
      if (!k_o) rises++;
      else falls++;
      if (i == 2) begin
        le_n_o <= 1'b1;
        a_o <= ~a;
      end
    end
    step(8);
    ce_n_o <= 1'b1;
    // oe stays low a while, so only chip enable can float the pins
    step(4);
    oe_n_o <= 1'b1;
  endtask
endmodule

// File: test/fhb_flash_if_tb_top.sv
// fhb_flash_if_tb_top: self-checking bench for the flash host bus port.
// assumes: host model on the pins, APB master tasks, array model below.
`timescale 1ns/10ps
module fhb_flash_if_tb_top import fhb_pkg::*;;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        ce_n, oe_n, we_n, le_n, rp_n, kclk;
  logic [20:0] host_a;
  logic [15:0] host_dq;
  logic [15:0] dq_wire;
  logic [15:0] data_pins_o;
  logic        data_pins_oe_n_o;
  logic        valid_ready_oe_n_o;
  logic [20:0] core_rd_addr;
  logic [15:0] core_rd_data = '0;
  logic        cmd_valid_o;
  logic [20:0] cmd_addr_o;
  logic [15:0] cmd_data_o;
  logic        pe_busy = 1'b1;
  logic        standby_o, low_power_o, power_down_o;
  logic        err;
  logic        rdy_seen = 1'b0;
  logic        drv_seen = 1'b0;
  int          n_cmd = 0;
  int          n_fail = 0;
  int          compares = 0;
  int          rises, falls;
  logic [31:0] r;

  always #5 mclk_i = ~mclk_i;

  fhb_flash_if u_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .chip_en_n_i(ce_n), .out_en_n_i(oe_n), .wr_en_n_i(we_n), .latch_en_n_i(le_n),
    .reset_power_down_n_i(rp_n), .burst_clk_i(kclk), .word_address_pins_i(host_a), .data_pins_i(dq_wire),
    .data_pins_o(data_pins_o), .data_pins_oe_n_o(data_pins_oe_n_o), .valid_ready_o(),
    .valid_ready_oe_n_o(valid_ready_oe_n_o), .core_rd_addr_o(core_rd_addr), .core_rd_data_i(core_rd_data),
    .cmd_valid_o(cmd_valid_o), .cmd_addr_o(cmd_addr_o), .cmd_data_o(cmd_data_o), .pe_busy_i(pe_busy),
    .standby_o(standby_o), .low_power_o(low_power_o), .power_down_o(power_down_o));

  fhb_host_model u_host (
    .mclk_i(mclk_i), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .le_n_o(le_n), .rp_n_o(rp_n),
    .k_o(kclk), .a_o(host_a), .dq_o(host_dq), .rises(rises), .falls(falls));

  // ==========================================================
  // wire level, array model, monitors
  assign dq_wire = (data_pins_oe_n_o === 1'b0) ? data_pins_o : host_dq;

  always @(posedge mclk_i) begin
    core_rd_data <= ~core_rd_addr[15:0];
    if (valid_ready_oe_n_o === 1'b0) rdy_seen <= 1'b1;
    if (data_pins_oe_n_o === 1'b0) drv_seen <= 1'b1;
    if (cmd_valid_o === 1'b1) n_cmd <= n_cmd + 1;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [15:0] cfg, input logic [20:0] a, input logic oe, input int edges);
    apb(1'b1, FHB_CFG_OFF, {16'h0, cfg});
    rdy_seen = 1'b0;
    drv_seen = 1'b0;
    fork
      u_host.burst(a, oe, 12);
      if (!oe) begin
        for (int i = 0; i < 400 && data_pins_oe_n_o !== 1'b0; i++) @(posedge mclk_i);
        chk(cfg[6] ? rises : falls, edges);
        repeat (4) @(posedge mclk_i);
        chk(data_pins_o, {16'h0, ~a[15:0]});
        for (int i = 0; i < 400 && standby_o !== 1'b1; i++) @(posedge mclk_i);
        chk(data_pins_oe_n_o, 1);
      end
    join
    repeat (6) @(posedge mclk_i);
    chk(data_pins_oe_n_o, 1);
  endtask

  task automatic conclude();
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (30) @(posedge mclk_i);
    chk(low_power_o, 0);
    apb(1'b0, FHB_CFG_OFF, '0);
    chk(r, 32'h8000);
    apb(1'b0, FHB_STATUS_OFF, '0);
    chk(r, 32'h11);
    // idle asynchronous read: low power must not stop the read data
    u_host.ce_n_o <= 1'b0;
    u_host.oe_n_o <= 1'b0;
    repeat (30) @(posedge mclk_i);
    chk(low_power_o, 1);
    chk(data_pins_oe_n_o, 0);
    chk(data_pins_o, 32'h0000ffff);
    apb(1'b0, FHB_STATUS_OFF, '0);
    chk(r, 32'h12);
    u_host.ce_n_o <= 1'b1;
    u_host.oe_n_o <= 1'b1;
    repeat (5) @(posedge mclk_i);
    chk(low_power_o, 0);
    apb(1'b0, 8'h10, '0);
    chk(r, 32'h0);
    chk({31'h0, err}, 32'h1);
    u_host.wr(1'b0, 21'h00a5a5, 16'h1234);
    chk(n_cmd, 1);
    chk({11'h0, cmd_addr_o}, 32'h0000a5a5);
    chk({16'h0, cmd_data_o}, 32'h00001234);
    u_host.wr(1'b1, 21'h1f0f0f, 16'hbeef);
    chk(n_cmd, 2);
    apb(1'b0, FHB_CMD_ADDR_OFF, '0);
    chk(r, 32'h001f0f0f);
    apb(1'b0, FHB_CMD_DATA_OFF, '0);
    chk(r, 32'h0000beef);
    for (int c = 2; c <= 6; c++)
      run(16'h0007 | (16'(c) << 11) | (16'(c % 2) << 6), 21'h000100, 1'b0, c + 3);
    chk(rdy_seen, 0);
    run(16'h1047, 21'h000101, 1'b1, 0);
    chk({rdy_seen, drv_seen}, 2'b10);
    run(16'h9047, 21'h000101, 1'b1, 0);
    chk({rdy_seen, drv_seen}, 2'b00);
    u_host.rp_n_o <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk({power_down_o, data_pins_oe_n_o, valid_ready_oe_n_o}, 3'b111);
    apb(1'b0, FHB_CFG_OFF, '0);
    chk(r, 32'h8000);
    conclude();
  end

  initial begin
    repeat (30000) @(posedge mclk_i);
    n_fail++;
    conclude();
  end
endmodule
